// ==== logic/dcsw_pkg.sv ====
package dcsw_pkg;
  // function codes of the input-to-accumulator operation
  localparam logic [2:0] FC_CLEAR = 3'h0;
  localparam logic [2:0] FC_COND = 3'h1;
  localparam logic [2:0] FC_FADDR = 3'h2;
  localparam logic [2:0] FC_WPTR = 3'h3;
  localparam logic [2:0] FC_CKW = 3'h4;
  localparam logic [2:0] FC_DCYL = 3'h5;
  // condition word bit positions
  localparam int B_ONCYL = 3;
  localparam int B_EOP = 4;
  localparam int B_ALARM = 5;
  localparam int B_MISCMP = 6;
  localparam int B_PROT = 7;
  localparam int B_CKWERR = 8;
  localparam int B_LOST = 9;
  localparam int B_ADDR = 10;
  localparam int B_CSEEK = 11;
  localparam int B_SDEN = 12;
  localparam int B_PAR = 13;
  localparam int B_PFLT = 14;
  localparam int B_DSEEK = 15;
  // drive cylinder word layout
  localparam int CYL_LSB = 7;
  localparam int CYL_W = 9;
  localparam logic [2:0] CYL_PAD = 3'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // end-of-operation lag behind busy falling, 30 to 50 ns
  localparam int CLK_NS = 25;
  localparam int EOP_LAG_MIN_NS = 30;
  localparam int EOP_LAG_CYC = (EOP_LAG_MIN_NS + CLK_NS - 1) / CLK_NS;
  // answer lag: 400 ns after the read strobe
  localparam int REPLY_NS = 400;
  localparam int REPLY_CYC = (REPLY_NS + CLK_NS - 1) / CLK_NS;
endpackage : dcsw_pkg

// ==== logic/dcsw_status.sv ====
module dcsw_status #(
  parameter int UNITS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // accumulator channel
  input wire logic aq_read,
  input wire logic [2:0] aq_func,
  input wire logic out_accept,
  output logic aq_reply,
  output logic aq_reject,
  output logic [15:0] aq_data,
  // controller state and events, same clock
  input wire logic busy,
  input wire logic op_done,
  input wire logic clear_ctl,
  input wire logic ev_miscmp,
  input wire logic ev_ckwerr,
  input wire logic ev_lost,
  input wire logic ev_addr,
  input wire logic ev_cseek,
  input wire logic ev_par,
  input wire logic ev_pflt,
  input wire logic [1:0] unit_sel,
  input wire logic [UNITS-1:0] unit_cmd,
  input wire logic [15:0] file_addr,
  input wire logic [15:0] memory_word_pointer,
  input wire logic [15:0] checkword,
  input wire logic [dcsw_pkg::CYL_W-1:0] disk_cyl,
  // drive pins
  input wire logic [UNITS-1:0] drv_ready,
  input wire logic [UNITS-1:0] drv_oncyl,
  input wire logic [UNITS-1:0] drv_protect,
  input wire logic [UNITS-1:0] drv_single,
  input wire logic [UNITS-1:0] drv_seek_done,
  input wire logic [UNITS-1:0] drv_seek_err,
  input wire logic [UNITS-1:0] drv_fault,
  // status outputs
  output logic alarm_irq_req,
  output logic [15:0] condition_word,
  output logic [15:0] drive_cylinder_word
);
  import dcsw_pkg::*;

  localparam int RW = $clog2(REPLY_CYC + 1);

  typedef enum logic [1:0] {
    DCSW_IDLE = 2'b00,
    DCSW_WAIT = 2'b01,
    DCSW_HOLD = 2'b11
  } dcsw_state_t;

  // pin synchronisers, two stages each; cleared in reset so that
  // no sticky flag latches an unknown pin level after reset
  logic [6*UNITS-1:0] pin_s1, pin_s2;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {drv_ready, drv_oncyl, drv_protect, drv_single,
                 drv_seek_done, drv_seek_err};
      pin_s2 <= pin_s1;
    end
  end
  wire [UNITS-1:0] s_ready = pin_s2[6*UNITS-1 -: UNITS];
  wire [UNITS-1:0] s_oncyl = pin_s2[5*UNITS-1 -: UNITS];
  wire [UNITS-1:0] s_prot = pin_s2[4*UNITS-1 -: UNITS];
  wire [UNITS-1:0] s_single = pin_s2[3*UNITS-1 -: UNITS];
  wire [UNITS-1:0] s_sdone = pin_s2[2*UNITS-1 -: UNITS];
  wire [UNITS-1:0] s_serr = pin_s2[UNITS-1:0];

  logic [UNITS-1:0] flt_s1, flt_s2;
  always_ff @(posedge clk) begin
    if (srst) begin
      flt_s1 <= '0;
      flt_s2 <= '0;
    end else begin
      flt_s1 <= drv_fault;
      flt_s2 <= flt_s1;
    end
  end

  // sticky flags
  logic eop, alarm, miscmp, ckwerr, lost, addr_err, cseek, par, pflt;
  logic busy_q, seek_q, deferred;
  logic [UNITS-1:0] sk_done, sk_err, sdone_q;
  logic [EOP_LAG_CYC-2:0] busy_fall_dly;

  // selected unit lines
  wire sel_ready = s_ready[unit_sel];
  wire sel_oncyl = s_oncyl[unit_sel];
  wire sel_serr = sk_err[unit_sel];
  wire dseek = sel_serr;
  wire busy_fall = busy_q & ~busy;
  wire [UNITS-1:0] sdone_rise = s_sdone & ~sdone_q;
  wire eop_set = busy_fall_dly[EOP_LAG_CYC-2] | (|sdone_rise) |
                 (op_done & ~busy);
  wire fault_any = |flt_s2;
  wire imm_alarm = (busy & ~sel_ready) | ev_cseek | ev_addr |
                   (dseek & ~seek_q) | fault_any;
  wire late_alarm = eop_set & (deferred | ev_ckwerr | ev_lost | ev_par |
                               ev_pflt);
  wire clr = out_accept;

  // busy edge delayed into the 30..50 ns window
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      busy_fall_dly <= '0;
      seek_q <= 1'b0;
      sdone_q <= '0;
    end else begin
      busy_q <= busy;
      // one tap less: the eop flag register already costs a cycle
      busy_fall_dly <= (EOP_LAG_CYC-1)'({busy_fall_dly, busy_fall});
      seek_q <= dseek;
      sdone_q <= s_sdone;
    end
  end

  // setting wins over the out_accept clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      eop <= 1'b0;
      alarm <= 1'b0;
      miscmp <= 1'b0;
      ckwerr <= 1'b0;
      lost <= 1'b0;
      addr_err <= 1'b0;
      cseek <= 1'b0;
      par <= 1'b0;
      pflt <= 1'b0;
      deferred <= 1'b0;
    end else begin
      eop <= eop_set | (eop & ~clr);
      alarm <= imm_alarm | late_alarm | (alarm & ~clr);
      miscmp <= ev_miscmp | (miscmp & ~clr);
      ckwerr <= ev_ckwerr | (ckwerr & ~clr);
      lost <= ev_lost | (lost & ~clr);
      addr_err <= ev_addr | (addr_err & ~clr);
      cseek <= ev_cseek | (cseek & ~clr);
      par <= ev_par | (par & ~clr);
      pflt <= ev_pflt | (pflt & ~clr);
      // a deferred cause waits here for end of operation
      deferred <= ~eop_set & (deferred | ev_ckwerr | ev_lost | ev_par |
                              ev_pflt);
    end
  end

  // per-unit seek results, visible without selection
  always_ff @(posedge clk) begin
    if (srst) begin
      sk_done <= '0;
      sk_err <= '0;
    end else begin
      sk_done <= (sk_done & ~unit_cmd) | (s_sdone & ~s_serr);
      // errors persist; clear only for the selected unit on clear
      sk_err <= s_serr | (sk_err &
                ~(clear_ctl ? (UNITS'(1) << unit_sel) : '0));
    end
  end

  // status word assembly; write protect of the selected unit is bit 7
  wire [15:0] cond_next = {dseek, pflt, par, s_single[unit_sel], cseek,
    addr_err, lost, ckwerr, s_prot[unit_sel], miscmp, alarm, eop,
    sel_oncyl & ~sel_serr, 3'h0};
  wire [15:0] dcyl_next = {disk_cyl, CYL_PAD,
                           4'(sk_done | sk_err)};

  // status selection by function code
  wire fc_legal = aq_func <= FC_DCYL;
  logic [15:0] sel_word;
  always_comb begin
    case (aq_func)
      FC_COND: sel_word = cond_next;
      FC_FADDR: sel_word = file_addr;
      FC_WPTR: sel_word = memory_word_pointer;
      FC_CKW: sel_word = checkword;
      FC_DCYL: sel_word = dcyl_next;
      default: sel_word = WORD_RESET;
    endcase
  end

  // channel handshake: answer after the lag, drop with the strobe
  dcsw_state_t st, next_st;
  logic [RW-1:0] cnt;
  logic rd_s1, rd_s2;
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_s1 <= 1'b0;
      rd_s2 <= 1'b0;
    end else begin
      rd_s1 <= aq_read;
      rd_s2 <= rd_s1;
    end
  end
  always_comb begin
    case (st)
      DCSW_IDLE: next_st = rd_s2 ? DCSW_WAIT : DCSW_IDLE;
      DCSW_WAIT: next_st = !rd_s2 ? DCSW_IDLE :
        (cnt == RW'(REPLY_CYC - 1)) ? DCSW_HOLD : DCSW_WAIT;
      DCSW_HOLD: next_st = rd_s2 ? DCSW_HOLD : DCSW_IDLE;
      default: next_st = DCSW_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= DCSW_IDLE;
      cnt <= '0;
      aq_reply <= 1'b0;
      aq_reject <= 1'b0;
      aq_data <= WORD_RESET;
      condition_word <= WORD_RESET;
      drive_cylinder_word <= WORD_RESET;
      alarm_irq_req <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= (st == DCSW_WAIT) ? cnt + RW'(1) : '0;
      aq_reply <= (next_st == DCSW_HOLD) & fc_legal;
      aq_reject <= (next_st == DCSW_HOLD) & ~fc_legal;
      aq_data <= ((next_st == DCSW_HOLD) & fc_legal) ? sel_word
                                                     : WORD_RESET;
      condition_word <= cond_next;
      drive_cylinder_word <= dcyl_next;
      alarm_irq_req <= alarm;
    end
  end

  // checks
  a_clear_flags: assert property (@(posedge clk) disable iff (srst)
    out_accept && !ev_miscmp |=> !miscmp)
    else $error("miscompare not cleared by output");
  a_eop_lag: assert property (@(posedge clk) disable iff (srst)
    busy_fall |-> ##[1:2] eop)
    else $error("end of operation late after busy fell");
  a_alarm_now: assert property (@(posedge clk) disable iff (srst)
    ev_cseek |=> alarm && cseek)
    else $error("alarm not immediate");
  a_miscmp_set: assert property (@(posedge clk) disable iff (srst)
    ev_miscmp |=> miscmp)
    else $error("miscompare not set");
  a_ckw_set: assert property (@(posedge clk) disable iff (srst)
    ev_ckwerr |=> ckwerr)
    else $error("checkword error not set");
  a_lost_set: assert property (@(posedge clk) disable iff (srst)
    ev_lost |=> lost)
    else $error("lost data not set");
  a_par_set: assert property (@(posedge clk) disable iff (srst)
    ev_par |=> par)
    else $error("parity flag not set");
  a_pflt_set: assert property (@(posedge clk) disable iff (srst)
    ev_pflt |=> pflt)
    else $error("protect fault not set");
  a_cyl_pad: assert property (@(posedge clk) disable iff (srst)
    drive_cylinder_word[6:4] == 3'h0)
    else $error("drive cylinder pad not zero");
  a_prot_bit: assert property (@(posedge clk) disable iff (srst)
    condition_word[B_PROT] == $past(s_prot[unit_sel]))
    else $error("protected bit wrong");
  // selected-unit status bits and fault path
  a_oncyl_bit: assert property (@(posedge clk) disable iff (srst)
    condition_word[B_ONCYL] == $past(sel_oncyl & ~sel_serr))
    else $error("on-cylinder bit wrong");
  a_sden_bit: assert property (@(posedge clk) disable iff (srst)
    condition_word[B_SDEN] == $past(s_single[unit_sel]))
    else $error("single-density bit wrong");
  a_fault_alarm: assert property (@(posedge clk) disable iff (srst)
    fault_any |=> alarm)
    else $error("drive fault did not raise alarm");
  a_alarm_clear: assert property (@(posedge clk) disable iff (srst)
    out_accept && !imm_alarm && !late_alarm |=> !alarm)
    else $error("alarm not cleared by output");
  a_seek_clear: assert property (@(posedge clk) disable iff (srst)
    unit_cmd[0] && !s_sdone[0] |=> !sk_done[0])
    else $error("seek complete not cleared by command");
  a_dcyl_seek: assert property (@(posedge clk) disable iff (srst)
    drive_cylinder_word[3:0] == $past(4'(sk_done | sk_err)))
    else $error("unit seek bits wrong");
  a_reject_zero: assert property (@(posedge clk) disable iff (srst)
    aq_reject |-> aq_data == WORD_RESET)
    else $error("refused read returned data");
endmodule : dcsw_status

// ==== sim/dcsw_drive_model.sv ====
module dcsw_drive_model (
  // clock
  input wire logic clk,
  // new positioning command, one bit a unit
  input wire logic [3:0] seek_go,
  // drive pins
  output logic [3:0] drv_oncyl,
  output logic [3:0] drv_seek_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [4] = '{default: 0};
  // travel outlasts a status read, so a read lands mid-move
  always @(posedge clk) begin
    for (int u = 0; u < 4; u++) begin
      if (seek_go[u]) cnt[u] = 48;
      else if (cnt[u] > 0) cnt[u] = cnt[u] - 1;
      drv_oncyl[u] <= (cnt[u] == 0);
      drv_seek_done[u] <= (cnt[u] > 0 && cnt[u] < 5);
    end
  end
endmodule : dcsw_drive_model

// ==== sim/dcsw_status_tb_top.sv ====
module dcsw_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dcsw_pkg::*;
  logic clk = 0, srst = 1, aq_read = 0, out_accept = 0, busy = 0;
  logic op_done = 0, aq_reply, aq_reject, alarm_irq_req, ans = 0;
  logic [2:0] aq_func = 0;
  logic [6:0] ev = 0;
  logic [3:0] unit_cmd = 0, drv_fault = 0, prot, sngl, oncyl, sdone;
  logic [15:0] aq_data, cw, dcw, fa, wp, ck, base;
  logic [8:0] cyl;
  logic [16:0] exp_q[$];
  int fail_count = 0, n_tests = 0, cyc = 0;
  int bp[7] = '{B_MISCMP, B_CKWERR, B_LOST, B_ADDR, B_CSEEK, B_PAR, B_PFLT};
  always #12.5 clk = ~clk;
  dcsw_drive_model dcsw_drive_model_inst (.clk(clk), .seek_go(unit_cmd),
    .drv_oncyl(oncyl), .drv_seek_done(sdone));
  dcsw_status dcsw_status_inst (.clk(clk), .srst(srst), .aq_read(aq_read),
    .aq_func(aq_func), .out_accept(out_accept), .aq_reply(aq_reply),
    .aq_reject(aq_reject), .aq_data(aq_data), .busy(busy),
    .op_done(op_done), .clear_ctl(1'b0), .ev_miscmp(ev[0]),
    .ev_ckwerr(ev[1]), .ev_lost(ev[2]), .ev_addr(ev[3]), .ev_cseek(ev[4]),
    .ev_par(ev[5]), .ev_pflt(ev[6]), .unit_sel(2'h0), .unit_cmd(unit_cmd),
    .file_addr(fa), .memory_word_pointer(wp), .checkword(ck),
    .disk_cyl(cyl), .drv_ready(4'hf), .drv_oncyl(oncyl),
    .drv_protect(prot), .drv_single(sngl), .drv_seek_done(sdone),
    .drv_seek_err(4'h0), .drv_fault(drv_fault),
    .alarm_irq_req(alarm_irq_req), .condition_word(cw),
    .drive_cylinder_word(dcw));
  task automatic chk(input logic [16:0] got, input logic [16:0] want);
    n_tests++;
    if (got !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic report_and_stop;
    if (exp_q.size() != 0) fail_count++;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // read strobe held until the answer shows, then released
  task automatic rd(input logic [2:0] f, input logic [16:0] e);
    int n = 0;
    @(negedge clk);
    aq_func = f;
    aq_read = 1;
    exp_q.push_back(e);
    while (aq_reply !== 1'b1 && aq_reject !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) fail_count++;
    aq_read = 0;
    repeat (8) @(negedge clk);
  endtask : rd
  task automatic pulse_clear;
    @(negedge clk);
    out_accept = 1;
    @(negedge clk);
    out_accept = 0;
  endtask : pulse_clear
  // oldest note against each answer as it rises
  always @(negedge clk) begin
    if ((aq_reply === 1'b1 || aq_reject === 1'b1) && !ans)
      chk({aq_reject, aq_data}, exp_q.pop_front());
    ans <= (aq_reply === 1'b1 || aq_reject === 1'b1);
  end
  // hang guard, well past the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(32'h25fe1953));
    {prot, sngl, cyl, fa} = {$urandom, $urandom};
    {wp, ck} = $urandom;
    base = {3'h0, sngl[0], 4'h0, prot[0], 3'h0, 1'b1, 3'h0};
    repeat (2) @(negedge clk);
    srst = 0;
    repeat (4) @(negedge clk);
    rd(0, 0);
    rd(1, {1'b0, base});
    rd(2, {1'b0, fa});
    rd(3, {1'b0, wp});
    rd(4, {1'b0, ck});
    rd(5, {1'b0, cyl, 7'h00});
    rd(6, 17'h10000);
    rd(7, 17'h10000);
    // each flag alone; address and seek errors alarm at once
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      ev = 7'h01 << i;
      @(negedge clk);
      ev = 0;
      rd(1, {1'b0, base | 16'h1 << bp[i] | (i inside {3, 4} ? 16'h20 : 0)});
      @(negedge clk);
      op_done = 1;
      @(negedge clk);
      op_done = 0;
      rd(1, {1'b0, base | 16'h1 << bp[i] | (i > 0 ? 16'h30 : 16'h10)});
      pulse_clear;
      rd(1, {1'b0, base});
    end
    busy = 1;
    repeat (5) @(negedge clk);
    busy = 0;
    repeat (4) @(negedge clk);
    chk({1'b0, cw}, {1'b0, base | 16'h10});
    pulse_clear;
    unit_cmd = 4'h4;
    @(negedge clk);
    unit_cmd = 0;
    repeat (60) @(negedge clk);
    rd(5, {1'b0, cyl, 7'h04});
    rd(1, {1'b0, base | 16'h10});
    unit_cmd = 4'h5;
    @(negedge clk);
    unit_cmd = 0;
    rd(5, {1'b0, cyl, 7'h00});
    rd(1, {1'b0, base & ~16'h8 | 16'h10});
    repeat (40) @(negedge clk);
    pulse_clear;
    drv_fault = 4'h2;
    repeat (6) @(negedge clk);
    chk({1'b0, cw}, {1'b0, base | 16'h20});
    chk({16'h0, alarm_irq_req}, 17'h1);
    report_and_stop;
  end
endmodule : dcsw_status_tb_top
